// File: stm_pkg.sv
package stm_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_SLOT0_DELAY = 8'h1C;
    localparam logic [7:0] ADDR_PIN_SEL = 8'h1D;
    localparam logic [7:0] ADDR_CHAN2 = 8'h1F;
    localparam logic [7:0] ADDR_CHAN3 = 8'h20;

    localparam logic [7:0] RST_SLOT0_DELAY = 8'h00;
    localparam logic [7:0] RST_PIN_SEL = 8'h00;
    localparam logic [7:0] RST_CHAN2 = 8'h01;
    localparam logic [7:0] RST_CHAN3 = 8'h02;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CHAN2_EN_BIT = 5;
    localparam int CHAN3_SRC_LSB = 5;
    localparam int SLOT_LSB = 0;
    localparam int SLOT_W = 5;
    localparam int DELAY_W = 5;
    localparam int PIN_SEL_CHAN2_BIT = 1;
    localparam int PIN_SEL_CHAN3_BIT = 2;

    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_ADC = 2'h1;
    localparam logic [1:0] SRC_VBAT = 2'h2;
    localparam logic [1:0] SRC_RSVD = 2'h3;

    localparam logic [1:0] FMT_TDM = 2'h0;
    localparam logic [1:0] FMT_I2S = 2'h1;
    localparam logic [1:0] FMT_LJ = 2'h2;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int FIFO_DEPTH = 32;
    localparam int SLOT_BITS = 32;
    localparam int N_CHAN = 2;

    typedef struct packed {
        logic [1:0] source;
        logic [4:0] slot;
        logic pin_sel;
    } stm_chan_cfg_t;

endpackage : stm_pkg

// File: stm_fifo.sv
`timescale 1ns/1ns
module stm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // fill side
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    // drain side
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = wr_valid_in && wr_ready_out;
    wire pop = rd_valid_out && rd_ready_in;
    wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign wr_ready_out = (count != (AW + 1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign rd_data_out = mem[rd_ptr];

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // ----------------------------------------
    // pointers
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule : stm_fifo

// File: stm_slot_tx.sv
`timescale 1ns/1ns
// Overview of operation
// - channel 2 stays off the data pins while its enable bit is 0 and sends adc channel 2 words in its slot when 1.
// - channel 3 source 0 is off, 1 sends adc channel 3, 2 sends battery-voltage words, 3 is reserved and kept off.
// - each channel has a five-bit slot field that in tdm format picks slot 0 to 31 directly.
// - in i2s or left-justified format slot values 0-15 are left-half slots and 16-31 right-half slots 0-15.
// - after reset channel 2 sits in slot 1 and channel 3 in slot 2, both disabled with pins released.
// - a per-channel select bit puts the channel on the primary data pin (0) or the second data pin (1).
// - a five-bit delay shifts the start of slot 0, and every slot after it, by 0 to 31 bit clocks.
module stm_slot_tx #(
    parameter int SLOT_BITS = stm_pkg::SLOT_BITS,
    parameter int FIFO_DEPTH = stm_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // frame format
    input wire logic [1:0] fmt_in,
    // serial clock pins
    input wire logic bclk_in,
    input wire logic fsync_in,
    // sample streams
    input wire logic [SLOT_BITS-1:0] adc2_data_in,
    input wire logic adc2_valid_in,
    output logic adc2_ready_out,
    input wire logic [SLOT_BITS-1:0] adc3_data_in,
    input wire logic adc3_valid_in,
    output logic adc3_ready_out,
    input wire logic [SLOT_BITS-1:0] vbat_data_in,
    input wire logic vbat_valid_in,
    output logic vbat_ready_out,
    // data pins
    output logic serial_data_out_primary_out,
    output logic serial_data_out_primary_oe_out,
    output logic serial_data_out_second_out,
    output logic serial_data_out_second_oe_out
);

    localparam int LOG = $clog2(SLOT_BITS);
    localparam int CNT_W = $clog2(32 * SLOT_BITS + 64);
    localparam int N = stm_pkg::N_CHAN;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic sec_tx_chan2_enable;
    logic [4:0] sec_tx_chan2_slot;
    logic [1:0] sec_tx_chan3_source;
    logic [4:0] sec_tx_chan3_slot;
    logic [1:0] pin_sel;
    logic [4:0] sec_tx_slot0_delay;

    wire wr_chan2 = reg_wr_in && (reg_addr_in == stm_pkg::ADDR_CHAN2);
    wire wr_chan3 = reg_wr_in && (reg_addr_in == stm_pkg::ADDR_CHAN3);
    wire wr_pin_sel = reg_wr_in && (reg_addr_in == stm_pkg::ADDR_PIN_SEL);
    wire wr_delay = reg_wr_in && (reg_addr_in == stm_pkg::ADDR_SLOT0_DELAY);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sec_tx_chan2_enable <= stm_pkg::RST_CHAN2[stm_pkg::CHAN2_EN_BIT];
            sec_tx_chan2_slot <= stm_pkg::RST_CHAN2[stm_pkg::SLOT_LSB +: stm_pkg::SLOT_W];
            sec_tx_chan3_source <= stm_pkg::RST_CHAN3[stm_pkg::CHAN3_SRC_LSB +: 2];
            sec_tx_chan3_slot <= stm_pkg::RST_CHAN3[stm_pkg::SLOT_LSB +: stm_pkg::SLOT_W];
            pin_sel <= stm_pkg::RST_PIN_SEL[stm_pkg::PIN_SEL_CHAN2_BIT +: 2];
            sec_tx_slot0_delay <= stm_pkg::RST_SLOT0_DELAY[stm_pkg::DELAY_W-1:0];
        end else begin
            if (wr_chan2) begin
                sec_tx_chan2_enable <= reg_wdata_in[stm_pkg::CHAN2_EN_BIT];
                sec_tx_chan2_slot <= reg_wdata_in[stm_pkg::SLOT_LSB +: stm_pkg::SLOT_W];
            end
            if (wr_chan3) begin
                sec_tx_chan3_source <= reg_wdata_in[stm_pkg::CHAN3_SRC_LSB +: 2];
                sec_tx_chan3_slot <= reg_wdata_in[stm_pkg::SLOT_LSB +: stm_pkg::SLOT_W];
            end
            if (wr_pin_sel) begin
                pin_sel <= reg_wdata_in[stm_pkg::PIN_SEL_CHAN2_BIT +: 2];
            end
            if (wr_delay) begin
                sec_tx_slot0_delay <= reg_wdata_in[stm_pkg::DELAY_W-1:0];
            end
        end
    end

    // reserved bits read as zero
    wire [7:0] rd_chan2 = {2'h0, sec_tx_chan2_enable, sec_tx_chan2_slot};
    wire [7:0] rd_chan3 = {1'h0, sec_tx_chan3_source, sec_tx_chan3_slot};
    wire [7:0] rd_pin_sel = {5'h00, pin_sel, 1'h0};
    wire [7:0] rd_delay = {3'h0, sec_tx_slot0_delay};
    wire [7:0] rd_word = (reg_addr_in == stm_pkg::ADDR_CHAN2) ? rd_chan2 :
                         (reg_addr_in == stm_pkg::ADDR_CHAN3) ? rd_chan3 :
                         (reg_addr_in == stm_pkg::ADDR_PIN_SEL) ? rd_pin_sel :
                         (reg_addr_in == stm_pkg::ADDR_SLOT0_DELAY) ? rd_delay : 8'h00;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_word;
        end
    end

    stm_pkg::stm_chan_cfg_t cfg [N];
    assign cfg[0] = '{source: {1'b0, sec_tx_chan2_enable}, slot: sec_tx_chan2_slot, pin_sel: pin_sel[0]};
    assign cfg[1] = '{source: sec_tx_chan3_source, slot: sec_tx_chan3_slot, pin_sel: pin_sel[1]};

    // ----------------------------------------
    // pin synchronisers and frame timing
    // ----------------------------------------
    logic [stm_pkg::SYNC_STAGES-1:0] bclk_sync;
    logic [stm_pkg::SYNC_STAGES-1:0] fs_sync;
    logic bclk_lvl;
    logic fs_lvl;
    logic bclk_prev;
    logic fs_prev;
    logic half;
    logic [CNT_W-1:0] bit_cnt;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bclk_sync <= '0;
            fs_sync <= '0;
            bclk_lvl <= 1'b0;
            fs_lvl <= 1'b0;
            bclk_prev <= 1'b0;
        end else begin
            bclk_sync <= {bclk_sync[1:0], bclk_in};
            fs_sync <= {fs_sync[1:0], fsync_in};
            if (bclk_sync[1] == bclk_sync[2]) begin
                bclk_lvl <= bclk_sync[2];
            end
            if (fs_sync[1] == fs_sync[2]) begin
                fs_lvl <= fs_sync[2];
            end
            bclk_prev <= bclk_lvl;
        end
    end

    wire rise_ev = bclk_lvl && !bclk_prev;
    wire fall_ev = !bclk_lvl && bclk_prev;
    wire is_tdm = (fmt_in == stm_pkg::FMT_TDM);
    wire is_i2s = (fmt_in == stm_pkg::FMT_I2S);
    wire frame_start = is_tdm ? (fs_lvl && !fs_prev) : (fs_lvl != fs_prev);
    wire next_half = is_tdm ? 1'b0 : (is_i2s ? fs_lvl : !fs_lvl);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fs_prev <= 1'b0;
            half <= 1'b0;
            bit_cnt <= '1;
        end else if (rise_ev) begin
            fs_prev <= fs_lvl;
            if (frame_start) begin
                half <= next_half;
                bit_cnt <= '0;
            end else if (bit_cnt != CNT_MAX) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // slot position after the slot 0 delay and the i2s one-bit lag
    wire [CNT_W-1:0] lead = CNT_W'(sec_tx_slot0_delay) + CNT_W'(is_i2s);
    wire pos_ok = (bit_cnt >= lead);
    wire [CNT_W-1:0] pos = bit_cnt - lead;
    wire [CNT_W-1:0] slot_idx = pos >> LOG;
    wire slot_first = (pos[LOG-1:0] == '0);

    // ----------------------------------------
    // channel source muxing into the fifos
    // ----------------------------------------
    logic [SLOT_BITS-1:0] fifo_wdata [N];
    logic [N-1:0] fifo_wvalid;
    logic [N-1:0] fifo_wready;
    wire ch3_adc = (sec_tx_chan3_source == stm_pkg::SRC_ADC);
    wire ch3_vbat = (sec_tx_chan3_source == stm_pkg::SRC_VBAT);

    assign fifo_wdata[0] = adc2_data_in;
    assign fifo_wvalid[0] = adc2_valid_in && sec_tx_chan2_enable;
    assign adc2_ready_out = fifo_wready[0] && sec_tx_chan2_enable;
    assign fifo_wdata[1] = ch3_vbat ? vbat_data_in : adc3_data_in;
    assign fifo_wvalid[1] = (ch3_adc && adc3_valid_in) || (ch3_vbat && vbat_valid_in);
    assign adc3_ready_out = ch3_adc && fifo_wready[1];
    assign vbat_ready_out = ch3_vbat && fifo_wready[1];

    // ----------------------------------------
    // per-channel slot shifters
    // ----------------------------------------
    logic [N-1:0] chan_on;
    logic [N-1:0] chan_match;
    logic [N-1:0] chan_pop;
    logic [N-1:0] chan_drive;
    logic [N-1:0] next_bit;
    logic [SLOT_BITS-1:0] shreg [N];

    for (genvar i = 0; i < N; i++) begin : g_chan
        logic [SLOT_BITS-1:0] rd_data;
        logic rd_valid;
        logic [SLOT_BITS-1:0] next_sh;
        logic slot_hit;

        stm_fifo #(
            .WIDTH(SLOT_BITS),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .clk_in(clk_in),
            .arst_n_in(arst_n_in),
            .wr_data_in(fifo_wdata[i]),
            .wr_valid_in(fifo_wvalid[i]),
            .wr_ready_out(fifo_wready[i]),
            .rd_data_out(rd_data),
            .rd_valid_out(rd_valid),
            .rd_ready_in(chan_pop[i])
        );

        // reserved source code stays off
        assign chan_on[i] = (cfg[i].source == stm_pkg::SRC_ADC) || (cfg[i].source == stm_pkg::SRC_VBAT);
        assign slot_hit = is_tdm ? (slot_idx == CNT_W'(cfg[i].slot)) :
                          ((half == cfg[i].slot[4]) && (slot_idx == CNT_W'(cfg[i].slot[3:0])));
        assign chan_match[i] = chan_on[i] && pos_ok && slot_hit;
        assign chan_pop[i] = fall_ev && chan_match[i] && slot_first;
        assign next_sh = !chan_match[i] ? shreg[i] :
                         slot_first ? (rd_valid ? rd_data : '0) : {shreg[i][SLOT_BITS-2:0], 1'b0};
        assign next_bit[i] = next_sh[SLOT_BITS-1];

        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                shreg[i] <= '0;
                chan_drive[i] <= 1'b0;
            end else if (fall_ev) begin
                shreg[i] <= next_sh;
                chan_drive[i] <= chan_match[i];
            end
        end
    end

    // ----------------------------------------
    // pin drive, channel 2 wins a clash
    // ----------------------------------------
    wire [N-1:0] on_primary = chan_match & ~{cfg[1].pin_sel, cfg[0].pin_sel};
    wire [N-1:0] on_second = chan_match & {cfg[1].pin_sel, cfg[0].pin_sel};
    wire next_primary = on_primary[0] ? next_bit[0] : next_bit[1];
    wire next_second = on_second[0] ? next_bit[0] : next_bit[1];

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_data_out_primary_out <= 1'b0;
            serial_data_out_primary_oe_out <= 1'b0;
            serial_data_out_second_out <= 1'b0;
            serial_data_out_second_oe_out <= 1'b0;
        end else if (fall_ev) begin
            serial_data_out_primary_out <= (|on_primary) && next_primary;
            serial_data_out_primary_oe_out <= |on_primary;
            serial_data_out_second_out <= (|on_second) && next_second;
            serial_data_out_second_oe_out <= |on_second;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    property p_ch2_off;
        fall_ev && !sec_tx_chan2_enable |=> !chan_drive[0];
    endproperty
    a_ch2_off: assert property (p_ch2_off) else $error("channel 2 drives while disabled");

    property p_ch2_tdm_slot;
        fall_ev && is_tdm && sec_tx_chan2_enable && pos_ok && (slot_idx == CNT_W'(sec_tx_chan2_slot))
            |=> chan_drive[0];
    endproperty
    a_ch2_tdm_slot: assert property (p_ch2_tdm_slot) else $error("channel 2 silent in its tdm slot");

    property p_ch3_off;
        fall_ev && ((sec_tx_chan3_source == stm_pkg::SRC_OFF) || (sec_tx_chan3_source == stm_pkg::SRC_RSVD))
            |=> !chan_drive[1];
    endproperty
    a_ch3_off: assert property (p_ch3_off) else $error("channel 3 drives with source off or reserved");

    property p_ch3_half;
        fall_ev && !is_tdm && ch3_vbat && pos_ok && (half == sec_tx_chan3_slot[4])
            && (slot_idx == CNT_W'(sec_tx_chan3_slot[3:0])) |=> chan_drive[1];
    endproperty
    a_ch3_half: assert property (p_ch3_half) else $error("channel 3 silent in its half-frame slot");

    property p_reset_vals;
        @(posedge clk_in) disable iff (1'b0)
        !arst_n_in |-> (sec_tx_chan2_slot == 5'h01) && (sec_tx_chan3_slot == 5'h02) && !sec_tx_chan2_enable
            && (sec_tx_chan3_source == 2'h0) && !serial_data_out_primary_oe_out && !serial_data_out_second_oe_out;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong state during reset");

    property p_rsvd_zero;
        reg_rd_in && ((reg_addr_in == stm_pkg::ADDR_CHAN2) || (reg_addr_in == stm_pkg::ADDR_CHAN3))
            |=> (reg_rdata_out[7] == 1'b0) && ($past(reg_addr_in) == stm_pkg::ADDR_CHAN3 || !reg_rdata_out[6]);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_pin_sel;
        fall_ev && chan_match[0] && pin_sel[0] |=> serial_data_out_second_oe_out && chan_drive[0];
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("channel 2 missing on second pin");

    property p_delay;
        fall_ev && (bit_cnt < CNT_W'(sec_tx_slot0_delay))
            |=> !serial_data_out_primary_oe_out && !serial_data_out_second_oe_out;
    endproperty
    a_delay: assert property (p_delay) else $error("pin driven inside slot 0 delay");

    property p_release;
        !fall_ev |=> $stable(serial_data_out_primary_oe_out) && $stable(serial_data_out_second_oe_out)
            && (serial_data_out_primary_oe_out || serial_data_out_second_oe_out || !(|chan_drive));
    endproperty
    a_release: assert property (p_release) else $error("pin enable out of step with slots");

    c_ch2_second: cover property (fall_ev && chan_match[0] && pin_sel[0]);
    c_ch3_vbat: cover property (chan_pop[1] && ch3_vbat);
    c_right_half: cover property (fall_ev && !is_tdm && half && (|chan_match));
    c_fifo_full: cover property (!fifo_wready[0]);

endmodule : stm_slot_tx

// File: stm_host_model.sv
`timescale 1ns/1ns
module stm_host_model #(
    parameter int HALF = 6
) (
    // clock
    input wire logic clk_in,
    // data pins
    input wire logic pri_in,
    input wire logic pri_oe_in,
    input wire logic sec_in,
    input wire logic sec_oe_in,
    // frame clocks
    output logic bclk_out,
    output logic fsync_out
);
    logic cap_oe [2][1024];
    logic cap_d [2][1024];
    initial begin
        bclk_out = 1'b0;
        fsync_out = 1'b0;
    end
    // ----------------------------------------
    // one frame, bits taken at bclk rise
    // ----------------------------------------
    task automatic run_frame(input logic [1:0] fmt, input int nb);
        logic idle;
        idle = (fmt == stm_pkg::FMT_I2S);
        // lead-in bit clock with frame sync at its idle level
        fsync_out = idle;
        repeat (HALF) @(negedge clk_in);
        bclk_out = 1'b1;
        repeat (HALF) @(negedge clk_in);
        bclk_out = 1'b0;
        for (int k = 0; k <= nb; k++) begin
            if (fmt == stm_pkg::FMT_TDM) begin
                fsync_out = (k == 0);
            end else begin
                fsync_out = (k < nb / 2 || k == nb) ? ~idle : idle;
            end
            repeat (HALF) @(negedge clk_in);
            bclk_out = 1'b1;
            if (k > 0) begin
                cap_oe[0][k-1] = pri_oe_in;
                cap_d[0][k-1] = pri_in;
                cap_oe[1][k-1] = sec_oe_in;
                cap_d[1][k-1] = sec_in;
            end
            repeat (HALF) @(negedge clk_in);
            bclk_out = 1'b0;
        end
    endtask : run_frame
endmodule : stm_host_model

// File: test_stm_slot_tx.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_total++; $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module test_stm_slot_tx;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b1;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic [1:0] fmt_in = 2'h0;
    logic bclk, fsync, pri, pri_oe, sec, sec_oe;
    logic [31:0] adc2_data_in = 32'h0, adc3_data_in = 32'h0, vbat_data_in = 32'h0;
    logic adc2_valid_in = 1'b0, adc3_valid_in = 1'b0, vbat_valid_in = 1'b0;
    logic adc2_ready_out, adc3_ready_out, vbat_ready_out;
    int err_total = 0, n_tests = 0;
    logic [7:0] ra [5] = '{stm_pkg::ADDR_CHAN2, stm_pkg::ADDR_CHAN3, stm_pkg::ADDR_PIN_SEL, stm_pkg::ADDR_SLOT0_DELAY, 8'h1E};
    logic [7:0] rv [5] = '{stm_pkg::RST_CHAN2, stm_pkg::RST_CHAN3, stm_pkg::RST_PIN_SEL, stm_pkg::RST_SLOT0_DELAY, 8'h00};
    logic [7:0] rm [5] = '{8'h3F, 8'h7F, 8'h06, 8'h1F, 8'h00};
    always #5 clk_in = ~clk_in;
    stm_slot_tx u_dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .fmt_in(fmt_in),
        .bclk_in(bclk), .fsync_in(fsync),
        .adc2_data_in(adc2_data_in), .adc2_valid_in(adc2_valid_in), .adc2_ready_out(adc2_ready_out),
        .adc3_data_in(adc3_data_in), .adc3_valid_in(adc3_valid_in), .adc3_ready_out(adc3_ready_out),
        .vbat_data_in(vbat_data_in), .vbat_valid_in(vbat_valid_in), .vbat_ready_out(vbat_ready_out),
        .serial_data_out_primary_out(pri), .serial_data_out_primary_oe_out(pri_oe),
        .serial_data_out_second_out(sec), .serial_data_out_second_oe_out(sec_oe)
    );
    stm_host_model u_host (
        .clk_in(clk_in), .pri_in(pri), .pri_oe_in(pri_oe), .sec_in(sec), .sec_oe_in(sec_oe),
        .bclk_out(bclk), .fsync_out(fsync)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic do_reset();
        arst_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
    endtask : do_reset
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        `CHK("reg_rdata", ex, reg_rdata_out)
    endtask : reg_read
    function automatic int bit_at(input logic [1:0] fmt, input int b, input int nb, input int dly, input logic [4:0] f);
        int h, pos;
        h = (fmt != stm_pkg::FMT_TDM && b >= nb / 2) ? 1 : 0;
        pos = b - h * (nb / 2) - dly - ((fmt == stm_pkg::FMT_I2S) ? 1 : 0);
        if (pos < 0) return -1;
        if (fmt == stm_pkg::FMT_TDM) return (pos / 32 == f) ? pos % 32 : -1;
        return (pos / 32 == f[3:0] && h == f[4]) ? pos % 32 : -1;
    endfunction : bit_at
    task automatic check_frame(input logic [1:0] fmt, input int nb, input int dly, input logic [7:0] r2,
        input logic [7:0] r3, input logic [7:0] ps, input logic [31:0] w2, input logic [31:0] w3);
        int i2, i3;
        logic eo, ed;
        for (int b = 0; b < nb; b++) begin
            i2 = bit_at(fmt, b, nb, dly, r2[4:0]);
            i3 = bit_at(fmt, b, nb, dly, r3[4:0]);
            for (int p = 0; p < 2; p++) begin
                eo = 1'b0;
                ed = 1'b0;
                if ((r3[6:5] == stm_pkg::SRC_ADC || r3[6:5] == stm_pkg::SRC_VBAT) && ps[2] == p && i3 >= 0) begin
                    eo = 1'b1;
                    ed = w3[31-i3];
                end
                if (r2[5] && ps[1] == p && i2 >= 0) begin
                    eo = 1'b1;
                    ed = w2[31-i2];
                end
                `CHK("pin_oe", eo, u_host.cap_oe[p][b])
                if (eo) `CHK("pin_data", ed, u_host.cap_d[p][b])
            end
        end
    endtask : check_frame
    task automatic run_case(input logic [1:0] fmt, input logic [7:0] r2, input logic [7:0] r3, input logic [7:0] ps,
        input logic [4:0] dly, input int nb);
        logic [31:0] w2, w3;
        logic [2:0] rdy;
        w2 = $urandom();
        w3 = $urandom();
        do_reset();
        fmt_in <= fmt;
        reg_write(stm_pkg::ADDR_CHAN2, r2);
        reg_write(stm_pkg::ADDR_CHAN3, r3);
        reg_write(stm_pkg::ADDR_PIN_SEL, ps);
        reg_write(stm_pkg::ADDR_SLOT0_DELAY, {3'h0, dly});
        rdy = {r2[5], r3[6:5] == stm_pkg::SRC_ADC, r3[6:5] == stm_pkg::SRC_VBAT};
        @(negedge clk_in);
        `CHK("ready", rdy, {adc2_ready_out, adc3_ready_out, vbat_ready_out})
        @(posedge clk_in);
        {adc2_valid_in, adc3_valid_in, vbat_valid_in} <= rdy;
        adc2_data_in <= w2;
        adc3_data_in <= w3;
        vbat_data_in <= w3;
        @(posedge clk_in);
        {adc2_valid_in, adc3_valid_in, vbat_valid_in} <= 3'b000;
        u_host.run_frame(fmt, nb);
        check_frame(fmt, nb, dly, r2, r3, ps, w2, w3);
    endtask : run_case
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [4:0] s2, s3, dly;
        logic [31:0] q [$];
        logic [31:0] w;
        logic acc;
        void'($urandom(9));
        do_reset();
        @(negedge clk_in);
        `CHK("oe_rst", 2'b00, {pri_oe, sec_oe})
        `CHK("rdy_rst", 3'b000, {adc2_ready_out, adc3_ready_out, vbat_ready_out})
        foreach (ra[i]) reg_read(ra[i], rv[i]);
        foreach (ra[i]) reg_write(ra[i], rm[i]);
        foreach (ra[i]) reg_read(ra[i], rm[i]);
        s2 = 5'($urandom_range(30));
        s3 = 5'((s2 + 1 + $urandom_range(28)) % 31);
        dly = 5'($urandom_range(31));
        run_case(stm_pkg::FMT_TDM, 8'h3F, 8'h20, 8'h04, 5'h00, 1024);
        run_case(stm_pkg::FMT_TDM, {3'h1, s2}, {3'h2, s3}, {5'h0, 2'($urandom_range(3)), 1'b0}, dly, 1024);
        run_case(stm_pkg::FMT_I2S, 8'h31, 8'h2E, 8'h02, dly, 1024);
        run_case(stm_pkg::FMT_LJ, 8'h23, 8'h50, 8'h04, 5'($urandom_range(31)), 1024);
        run_case(stm_pkg::FMT_TDM, 8'h02, 8'h61, 8'h00, 5'h00, 128);
        do_reset();
        fmt_in <= stm_pkg::FMT_TDM;
        reg_write(stm_pkg::ADDR_CHAN2, 8'h20);
        w = $urandom();
        adc2_valid_in <= 1'b1;
        adc2_data_in <= w;
        acc = 1'b1;
        while (acc && q.size() < 40) begin
            @(negedge clk_in);
            acc = adc2_ready_out;
            @(posedge clk_in);
            if (acc) begin
                q.push_back(w);
                w = $urandom();
                adc2_data_in <= w;
            end
        end
        adc2_valid_in <= 1'b0;
        `CHK("fifo_fill", stm_pkg::FIFO_DEPTH, q.size())
        foreach (q[i]) begin
            u_host.run_frame(stm_pkg::FMT_TDM, 32);
            check_frame(stm_pkg::FMT_TDM, 32, 0, 8'h20, 8'h00, 8'h00, q[i], 32'h0);
            if (i == 0) `CHK("ready_free", 1'b1, adc2_ready_out)
        end
        finish_test();
    end
    initial begin
        #900000;
        err_total++;
        finish_test();
    end
endmodule : test_stm_slot_tx
